// *** core/tag_cmd_pkg.sv ***
// constants, types and register map of the tag command handler
// shared by the handler core and its random source
package tag_cmd_pkg;

	// register byte offsets on the apb
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_ARG      = 8'h04;
	localparam logic [7:0] OFF_GIVEN_LO = 8'h08;
	localparam logic [7:0] OFF_GIVEN_HI = 8'h0C;
	localparam logic [7:0] OFF_CONFIG   = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_UNIQ_LO  = 8'h18;
	localparam logic [7:0] OFF_UNIQ_HI  = 8'h1C;
	localparam logic [7:0] OFF_MEM      = 8'h20;

	// field positions
	localparam int ARG_ADDR_LSB  = 0;
	localparam int ARG_MASK_LSB  = 8;
	localparam int ARG_CMP_LSB   = 16;
	localparam int CFG_FLAGS_LSB = 0;
	localparam int CFG_WOK_BIT   = 8;
	localparam int ST_STATE_LSB  = 0;
	localparam int ST_BUSY_BIT   = 2;
	localparam int ST_LOCKV_BIT  = 3;
	localparam int ST_SLOT_LSB   = 8;
	localparam int ST_LOCKA_LSB  = 16;
	localparam int MEM_ADDR_LSB  = 0;
	localparam int MEM_DATA_LSB  = 8;

	// command codes
	localparam logic [7:0] OP_FLAG_MISMATCH_SELECT   = 8'h01;
	localparam logic [7:0] OP_FLAG_MATCH_DESELECT    = 8'h02;
	localparam logic [7:0] OP_FLAG_MISMATCH_DESELECT = 8'h03;
	localparam logic [7:0] OP_FAIL                   = 8'h04;
	localparam logic [7:0] OP_SUCCESS                = 8'h05;
	localparam logic [7:0] OP_RESEND                 = 8'h06;
	localparam logic [7:0] OP_INITIALIZE             = 8'h07;
	localparam logic [7:0] OP_READ                   = 8'h08;
	localparam logic [7:0] OP_MULTI_BLOCK_FETCH      = 8'h09;
	localparam logic [7:0] OP_SELECTED_FETCH         = 8'h0A;
	localparam logic [7:0] OP_VERIFY_BYTE            = 8'h0B;
	localparam logic [7:0] OP_VERIFY_QUAD_FETCH      = 8'h0C;

	// counts
	localparam logic [7:0]  SLOT_MAX    = 8'hFF;
	localparam logic [11:0] BLOCK_BYTES = 12'h008;
	localparam logic [11:0] QUAD_BYTES  = 12'h004;
	localparam logic [11:0] ONE_BYTE    = 12'h001;
	localparam int          QUAD_TOP    = 7;
	localparam logic [15:0] LFSR_TAPS   = 16'hB400;

	typedef enum logic [1:0] {
		TAG_READY    = 2'b00,
		TAG_SELECTED = 2'b01,
		TAG_TRANSFER = 2'b10
	} tag_state_e;

	typedef enum logic [0:0] {
		EX_IDLE = 1'b0,
		EX_SEND = 1'b1
	} exec_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} reply_s;

	typedef struct packed {
		tag_state_e  tag_st;
		exec_e       ex;
		logic [7:0]  slot;
		logic [7:0]  opcode;
		logic [7:0]  addr;
		logic [7:0]  mask;
		logic [7:0]  cmp;
		logic [63:0] given;
		logic [7:0]  flags;
		logic        write_ok;
		logic        lock_valid;
		logic [7:0]  lock_addr;
		logic [11:0] idx;
		logic [11:0] len;
		logic        src_mem;
		logic        quad;
		logic [31:0] prdata;
		reply_s      reply;
	} core_s;

	typedef struct packed {
		logic [15:0] lfsr;
	} rng_s;

	localparam core_s CORE_RESET = '0;

endpackage

// *** core/tag_rng.sv ***
// free running random bit source for collision arbitration
// one clock domain, reset seeds a nonzero pattern
`timescale 1ns/10ps
module tag_rng
	import tag_cmd_pkg::*;
#(
	parameter logic [15:0] SEED = 16'hACE1
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// random bit
	output logic      bit_out
);
	rng_s r_reg;
	rng_s r_next;

	// galois shift keeps one fresh bit every cycle
	always_comb begin
		r_next = r_reg;
		r_next.lfsr = {1'b0, r_reg.lfsr[15:1]} ^ (r_reg.lfsr[0] ? LFSR_TAPS : 16'h0000);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '{lfsr: SEED};
		end else begin
			r_reg <= r_next;
		end
	end

	assign bit_out = r_reg.lfsr[0];
endmodule

// *** core/tag_store.sv ***
// byte store of the tag: one write port, one combinational read port
// contents are undefined until software loads them
`timescale 1ns/10ps
module tag_store #(
	parameter int DEPTH = 256
) (
	// clock
	input  wire logic       pclk,
	// write port
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// read port
	input  wire logic [7:0] rd_addr,
	output logic [7:0]      rd_data
);
	logic [7:0] cells [DEPTH];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	assign rd_data = cells[rd_addr];
endmodule

// *** core/tag_cmd_core.sv ***
// tag side command handler: group select, arbitration and read commands
// software drives it over apb; replies leave as a byte stream to the encoder
// Notes on behaviour
// - ready, flags differ: clear slot, answer, select
// - flag select while selected: clear slot, answer
// - match deselect, flags equal: ready, silent
// - mismatch deselect, flags differ: ready, silent
// - failed deselect: clear slot, answer, stay
// - unmet conditions: no answer at all
// - fail: count up if nonzero or random, hold at max
// - answer after fail/success only at zero
// - success: count down unless already zero
// - resend: answer at zero, count unchanged
// - initialize: ready, leave transfer, silent
// - read on match: transfer, eight bytes
// - read, selected fetch and byte verify mark their address lockable
// - multi fetch returns mask plus one blocks
// - multi fetch past top still runs
// - selected fetch only selected or transfer
// - byte verify needs match and good write
// - quad verify needs match and good write
// - quad mask B7..B4 pick address plus 0..3
`timescale 1ns/10ps
module tag_cmd_core
	import tag_cmd_pkg::*;
#(
	// arbitrary value, replace per device
	parameter logic [63:0] UNIQUE_TAG_NUMBER = 64'h0123_4567_89AB_CDEF,
	parameter int          STORE_DEPTH       = 256
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// reply byte stream
	output reply_s           reply,
	input  wire logic        reply_ready
);
	core_s       s_reg;
	core_s       s_next;
	logic [7:0]  mem_rd_data;
	logic        rnd_bit;
	logic        busy;
	logic        wr_fire;
	logic        rd_setup;
	logic        wr_locked;
	logic        cmd_fire;
	logic [7:0]  op;
	logic        flags_ne;
	logic        number_match;
	logic [7:0]  fail_slot;
	logic [7:0]  succ_slot;
	logic [31:0] rd_word;
	logic        go;
	logic        go_mem;
	logic [11:0] go_len;
	logic        mark;

	function automatic logic is_mapped(input logic [7:0] a);
		return a inside {OFF_CMD, OFF_ARG, OFF_GIVEN_LO, OFF_GIVEN_HI, OFF_CONFIG,
			OFF_STATUS, OFF_UNIQ_LO, OFF_UNIQ_HI, OFF_MEM};
	endfunction

	// unique number goes out most significant byte first
	function automatic logic [7:0] number_byte(input logic [63:0] n, input logic [11:0] i);
		logic [5:0] sh;
		sh = {3'd7 - i[2:0], 3'b000};
		return n[sh +: 8];
	endfunction

	// true when a selected quad position follows position p
	function automatic logic later_sel(input logic [7:0] m, input logic [1:0] p);
		logic r;
		r = 1'b0;
		for (int q = 0; q < 4; q++) begin
			if (q > int'(p) && m[3'(QUAD_TOP - q)]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	tag_store #(
		.DEPTH(STORE_DEPTH)
	) u_store (
		.pclk   (pclk),
		.wr_en  (wr_fire && paddr == OFF_MEM),
		.wr_addr(pwdata[MEM_ADDR_LSB +: 8]),
		.wr_data(pwdata[MEM_DATA_LSB +: 8]),
		.rd_addr(s_reg.addr + s_reg.idx[7:0]),
		.rd_data(mem_rd_data)
	);

	tag_rng u_rng (
		.pclk   (pclk),
		.presetn(presetn),
		.bit_out(rnd_bit)
	);

	assign busy     = s_reg.ex != EX_IDLE;
	assign wr_fire  = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	// command arguments must not move under a reply in flight
	assign wr_locked = busy && (paddr == OFF_CMD || paddr == OFF_ARG
		|| paddr == OFF_GIVEN_LO || paddr == OFF_GIVEN_HI);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && (!is_mapped(paddr) || (pwrite && wr_locked));
	assign cmd_fire = wr_fire && paddr == OFF_CMD && !busy;
	assign op       = pwdata[7:0];
	assign flags_ne = s_reg.flags != s_reg.cmp;
	assign number_match = s_reg.given == UNIQUE_TAG_NUMBER;

	// counter only moves when nonzero or the random bit says back off
	assign fail_slot = (s_reg.slot != 8'h00 || rnd_bit)
		? ((s_reg.slot == SLOT_MAX) ? SLOT_MAX : s_reg.slot + 8'h01) : s_reg.slot;
	assign succ_slot = (s_reg.slot != 8'h00) ? s_reg.slot - 8'h01 : s_reg.slot;

	always_comb begin
		rd_word = '0;
		if (paddr == OFF_CMD) begin
			rd_word[7:0] = s_reg.opcode;
		end else if (paddr == OFF_ARG) begin
			rd_word[ARG_ADDR_LSB +: 8] = s_reg.addr;
			rd_word[ARG_MASK_LSB +: 8] = s_reg.mask;
			rd_word[ARG_CMP_LSB +: 8]  = s_reg.cmp;
		end else if (paddr == OFF_GIVEN_LO) begin
			rd_word = s_reg.given[31:0];
		end else if (paddr == OFF_GIVEN_HI) begin
			rd_word = s_reg.given[63:32];
		end else if (paddr == OFF_CONFIG) begin
			rd_word[CFG_FLAGS_LSB +: 8] = s_reg.flags;
			rd_word[CFG_WOK_BIT]        = s_reg.write_ok;
		end else if (paddr == OFF_STATUS) begin
			rd_word[ST_STATE_LSB +: 2] = s_reg.tag_st;
			rd_word[ST_BUSY_BIT]       = busy;
			rd_word[ST_LOCKV_BIT]      = s_reg.lock_valid;
			rd_word[ST_SLOT_LSB +: 8]  = s_reg.slot;
			rd_word[ST_LOCKA_LSB +: 8] = s_reg.lock_addr;
		end else if (paddr == OFF_UNIQ_LO) begin
			rd_word = UNIQUE_TAG_NUMBER[31:0];
		end else if (paddr == OFF_UNIQ_HI) begin
			rd_word = UNIQUE_TAG_NUMBER[63:32];
		end
	end

	always_comb begin
		s_next = s_reg;
		go     = 1'b0;
		go_mem = 1'b0;
		go_len = BLOCK_BYTES;
		mark   = 1'b0;

		// read data is fetched in the setup cycle, stands through access
		if (rd_setup) begin
			s_next.prdata = rd_word;
		end

		if (wr_fire && !wr_locked) begin
			if (paddr == OFF_ARG) begin
				s_next.addr = pwdata[ARG_ADDR_LSB +: 8];
				s_next.mask = pwdata[ARG_MASK_LSB +: 8];
				s_next.cmp  = pwdata[ARG_CMP_LSB +: 8];
			end else if (paddr == OFF_GIVEN_LO) begin
				s_next.given[31:0] = pwdata;
			end else if (paddr == OFF_GIVEN_HI) begin
				s_next.given[63:32] = pwdata;
			end else if (paddr == OFF_CONFIG) begin
				s_next.flags    = pwdata[CFG_FLAGS_LSB +: 8];
				s_next.write_ok = pwdata[CFG_WOK_BIT];
			end
		end

		// any branch that leaves go low sends nothing back
		if (cmd_fire) begin
			s_next.opcode = op;
			case (op)
				OP_FLAG_MISMATCH_SELECT: begin
					if (s_reg.tag_st == TAG_SELECTED) begin
						s_next.slot = 8'h00;
						go          = 1'b1;
					end else if (s_reg.tag_st == TAG_READY && flags_ne) begin
						s_next.slot   = 8'h00;
						s_next.tag_st = TAG_SELECTED;
						go            = 1'b1;
					end
				end
				OP_FLAG_MATCH_DESELECT: begin
					if (s_reg.tag_st == TAG_SELECTED) begin
						if (!flags_ne) begin
							s_next.tag_st = TAG_READY;
						end else begin
							s_next.slot = 8'h00;
							go          = 1'b1;
						end
					end
				end
				OP_FLAG_MISMATCH_DESELECT: begin
					if (s_reg.tag_st == TAG_SELECTED) begin
						if (flags_ne) begin
							s_next.tag_st = TAG_READY;
						end else begin
							s_next.slot = 8'h00;
							go          = 1'b1;
						end
					end
				end
				OP_FAIL: begin
					s_next.slot = fail_slot;
					go          = fail_slot == 8'h00;
				end
				OP_SUCCESS: begin
					s_next.slot = succ_slot;
					go          = succ_slot == 8'h00;
				end
				OP_RESEND: begin
					go = s_reg.slot == 8'h00;
				end
				OP_INITIALIZE: begin
					s_next.tag_st = TAG_READY;
				end
				OP_READ: begin
					if (number_match) begin
						s_next.tag_st = TAG_TRANSFER;
						go            = 1'b1;
						go_mem        = 1'b1;
						mark          = 1'b1;
					end
				end
				OP_MULTI_BLOCK_FETCH: begin
					// length may run past the top address; the store wraps
					if (number_match) begin
						s_next.tag_st = TAG_TRANSFER;
						go            = 1'b1;
						go_mem        = 1'b1;
						go_len        = ({4'h0, s_reg.mask} + 12'h001) << 3;
					end
				end
				OP_SELECTED_FETCH: begin
					if (s_reg.tag_st != TAG_READY && number_match) begin
						s_next.tag_st = TAG_TRANSFER;
						go            = 1'b1;
						go_mem        = 1'b1;
						mark          = 1'b1;
					end
				end
				OP_VERIFY_BYTE: begin
					if (number_match && s_reg.write_ok) begin
						s_next.tag_st = TAG_TRANSFER;
						go            = 1'b1;
						go_mem        = 1'b1;
						go_len        = ONE_BYTE;
						mark          = 1'b1;
					end
				end
				OP_VERIFY_QUAD_FETCH: begin
					if (number_match && s_reg.write_ok) begin
						s_next.tag_st = TAG_TRANSFER;
						go            = 1'b1;
						go_mem        = 1'b1;
						go_len        = QUAD_BYTES;
					end
				end
				default: begin
				end
			endcase
		end

		if (go) begin
			s_next.ex      = EX_SEND;
			s_next.idx     = 12'h000;
			s_next.len     = go_len;
			s_next.src_mem = go_mem;
			s_next.quad    = op == OP_VERIFY_QUAD_FETCH;
		end
		if (mark) begin
			s_next.lock_valid = 1'b1;
			s_next.lock_addr  = s_reg.addr;
		end

		// a byte is offered until taken; the next one loads on the taking edge
		if (s_reg.ex == EX_SEND && (!s_reg.reply.valid || reply_ready)) begin
			if (s_reg.idx == s_reg.len) begin
				s_next.reply.valid = 1'b0;
				s_next.reply.last  = 1'b0;
				s_next.ex          = EX_IDLE;
			end else begin
				s_next.reply.data  = s_reg.src_mem ? mem_rd_data
					: number_byte(UNIQUE_TAG_NUMBER, s_reg.idx);
				// quad positions whose mask bit is clear are skipped
				s_next.reply.valid = !s_reg.quad
					|| s_reg.mask[3'(QUAD_TOP - int'(s_reg.idx[1:0]))];
				s_next.reply.last  = s_reg.quad ? !later_sel(s_reg.mask, s_reg.idx[1:0])
					: (s_reg.idx == s_reg.len - 12'h001);
				s_next.idx         = s_reg.idx + 12'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= CORE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign reply  = s_reg.reply;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_select_from_ready:
	assert property (cmd_fire && op == OP_FLAG_MISMATCH_SELECT && s_reg.tag_st == TAG_READY
		&& flags_ne |=> s_reg.tag_st == TAG_SELECTED && s_reg.slot == 8'h00
		&& s_reg.ex == EX_SEND && !s_reg.src_mem ##1 reply.valid && reply.data
		== UNIQUE_TAG_NUMBER[63:56])
		else $error("select from ready did not answer with the number");

	chk_reselect_stays:
	assert property (cmd_fire && op == OP_FLAG_MISMATCH_SELECT
		&& s_reg.tag_st == TAG_SELECTED |=> s_reg.tag_st == TAG_SELECTED
		&& s_reg.slot == 8'h00 && s_reg.ex == EX_SEND)
		else $error("select while selected misbehaved");

	chk_match_deselect:
	assert property (cmd_fire && op == OP_FLAG_MATCH_DESELECT && s_reg.tag_st == TAG_SELECTED
		&& !flags_ne |=> s_reg.tag_st == TAG_READY && !busy [*3])
		else $error("equal deselect did not go ready silently");

	chk_mismatch_deselect:
	assert property (cmd_fire && op == OP_FLAG_MISMATCH_DESELECT
		&& s_reg.tag_st == TAG_SELECTED && flags_ne |=> s_reg.tag_st == TAG_READY && !busy)
		else $error("unequal deselect did not go ready silently");

	chk_deselect_refused:
	assert property (cmd_fire && s_reg.tag_st == TAG_SELECTED
		&& ((op == OP_FLAG_MATCH_DESELECT && flags_ne)
		|| (op == OP_FLAG_MISMATCH_DESELECT && !flags_ne))
		|=> s_reg.tag_st == TAG_SELECTED && s_reg.slot == 8'h00 && busy)
		else $error("failed deselect did not answer");

	chk_no_reply_unmatched:
	assert property (cmd_fire && !number_match && (op == OP_READ || op == OP_SELECTED_FETCH
		|| op == OP_MULTI_BLOCK_FETCH) |=> !busy && $stable(s_reg.tag_st))
		else $error("unmatched read answered");

	chk_fail_counts:
	assert property (cmd_fire && op == OP_FAIL && s_reg.slot != 8'h00 && s_reg.slot != SLOT_MAX
		|=> s_reg.slot == 8'($past(s_reg.slot) + 8'h01))
		else $error("fail did not count up");

	chk_fail_saturates:
	assert property (cmd_fire && op == OP_FAIL && s_reg.slot == SLOT_MAX
		|=> s_reg.slot == SLOT_MAX && !busy)
		else $error("slot counter wrapped");

	chk_count_answer:
	assert property (cmd_fire && (op == OP_FAIL || op == OP_SUCCESS)
		|=> busy == (s_reg.slot == 8'h00))
		else $error("arbitration answer does not follow the counter");

	chk_success_counts:
	assert property (cmd_fire && op == OP_SUCCESS
		|=> s_reg.slot == (($past(s_reg.slot) == 8'h00) ? 8'h00
		: 8'($past(s_reg.slot) - 8'h01)))
		else $error("success count wrong");

	chk_resend_keeps:
	assert property (cmd_fire && op == OP_RESEND
		|=> $stable(s_reg.slot) && busy == (s_reg.slot == 8'h00))
		else $error("resend changed count or answered wrongly");

	chk_init_ready:
	assert property (cmd_fire && op == OP_INITIALIZE |=> s_reg.tag_st == TAG_READY && !busy)
		else $error("initialize left state or answered");

	chk_read_fetch:
	assert property (cmd_fire && op == OP_READ && number_match |=> s_reg.tag_st == TAG_TRANSFER
		&& s_reg.len == BLOCK_BYTES && s_reg.src_mem && s_reg.lock_valid
		&& s_reg.lock_addr == s_reg.addr)
		else $error("read did not fetch eight bytes");

	chk_multi_len:
	assert property (cmd_fire && op == OP_MULTI_BLOCK_FETCH && number_match
		|=> s_reg.len == 12'(({4'h0, s_reg.mask} + 12'h001) * 12'h008))
		else $error("multi fetch length wrong");

	chk_selfetch_gate:
	assert property (cmd_fire && op == OP_SELECTED_FETCH && s_reg.tag_st == TAG_READY
		|=> !busy && s_reg.tag_st == TAG_READY)
		else $error("selected fetch ran from ready");

	chk_verify_gate:
	assert property (cmd_fire && (op == OP_VERIFY_BYTE || op == OP_VERIFY_QUAD_FETCH)
		&& !s_reg.write_ok |=> !busy)
		else $error("verify answered without a good write");

	chk_reply_holds:
	assert property (reply.valid && !reply_ready |=> $stable(reply))
		else $error("reply byte changed before taken");
endmodule

// *** verification/reply_sink.sv ***
// reply stream sink standing in for the return link encoder
// same clock as the handler; stall lets only one take in four cycles
`timescale 1ns/10ps
module reply_sink
	import tag_cmd_pkg::*;
(
	// clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// stream from the handler
	input  wire reply_s reply,
	output logic        reply_ready,
	// bench control
	input  wire logic   stall
);
	logic [7:0] got [0:2047];
	logic       lst [0:2047];
	int         cnt = 0;
	logic [1:0] ph  = 2'h0;

	initial reply_ready = 1'b0;

	always @(posedge pclk) begin
		ph <= ph + 2'h1;
		reply_ready <= presetn && (!stall || ph == 2'h3);
		if (reply.valid === 1'b1 && reply_ready === 1'b1 && cnt < 2048) begin
			got[cnt] <= reply.data;
			lst[cnt] <= reply.last;
			cnt <= cnt + 1;
		end
	end
endmodule

// *** verification/tb.sv ***
// self-checking bench of the tag command handler
// apb driven by the bench; reply bytes land in the sink model
`timescale 1ns/10ps
module tb
	import tag_cmd_pkg::*;
;
	// arbitrary value
	localparam logic [63:0] TAG_NUM = 64'h5A3C_96E1_0F72_B4D8;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	reply_s      reply;
	logic        reply_ready;
	logic        stall;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          cmp_count = 0;
	logic [7:0]  ex[$];

	always #5 pclk = ~pclk;

	tag_cmd_core #(.UNIQUE_TAG_NUMBER(TAG_NUM)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .reply(reply),
		.reply_ready(reply_ready));

	reply_sink sink_u (.pclk(pclk), .presetn(presetn), .reply(reply),
		.reply_ready(reply_ready), .stall(stall));

	function automatic logic [7:0] mv(input logic [7:0] a);
		return a ^ 8'hA5;
	endfunction

	task automatic summarize();
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_total++;
			summarize();
		end
	endtask

	// leaves the idle status word in rd
	task automatic issue(input logic [7:0] op);
		int n;
		apb(1'b1, OFF_CMD, {24'h0, op});
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (rd[ST_BUSY_BIT] !== 1'b0 && n < 400);
		if (n >= 400) begin
			err_total++;
			summarize();
		end
	endtask

	task automatic run(input logic [7:0] op);
		int b;
		b = sink_u.cnt;
		issue(op);
		check("reply count", ex.size(), sink_u.cnt - b);
		foreach (ex[i]) check("reply byte", ex[i], sink_u.got[b + i]);
		if (ex.size() > 0) check("reply last", 1, sink_u.lst[sink_u.cnt - 1]);
		foreach (ex[i]) if (i < ex.size() - 1) check("reply not last", 0, sink_u.lst[b + i]);
		ex.delete();
	endtask

	task automatic arg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] c);
		apb(1'b1, OFF_ARG, {8'h0, c, m, a});
	endtask

	task automatic push_num();
		for (int i = 7; i >= 0; i--) ex.push_back(TAG_NUM[i*8 +: 8]);
	endtask

	task automatic push_mem(input logic [7:0] a, input int n);
		for (int i = 0; i < n; i++) ex.push_back(mv(a + i[7:0]));
	endtask

	task automatic state_is(input logic [1:0] s);
		apb(1'b0, OFF_STATUS, 32'h0);
		check("state", s, rd[1:0]);
	endtask

	task automatic slot_is(input logic [7:0] v);
		check("slot", v, rd[ST_SLOT_LSB +: 8]);
	endtask

	task automatic lock_is(input logic [7:0] a);
		check("lock mark", {1'b1, a}, {rd[ST_LOCKV_BIT], rd[ST_LOCKA_LSB +: 8]});
	endtask

	task automatic t_regs();
		apb(1'b0, OFF_STATUS, 32'h0);
		check("status reset", 32'h0, rd);
		apb(1'b0, OFF_UNIQ_HI, 32'h0);
		check("uniq hi", TAG_NUM[63:32], rd);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped err", 1, er);
		for (int i = 0; i < 256; i++) apb(1'b1, OFF_MEM, {16'h0, mv(i[7:0]), i[7:0]});
	endtask

	task automatic t_arb();
		int b;
		int n;
		push_num();
		run(OP_SUCCESS);
		slot_is(8'h00);
		rd = 32'h0;
		for (n = 0; n < 60 && rd[15:8] == 8'h00; n++) begin
			b = sink_u.cnt;
			issue(OP_FAIL);
			check("fail reply", rd[15:8] == 8'h00 ? 8 : 0, sink_u.cnt - b);
		end
		slot_is(8'h01);
		run(OP_FAIL);
		slot_is(8'h02);
		run(OP_SUCCESS);
		slot_is(8'h01);
		run(OP_RESEND);
		push_num();
		run(OP_SUCCESS);
		push_num();
		run(OP_RESEND);
		slot_is(8'h00);
		for (n = 0; n < 600 && rd[15:8] !== 8'hFF; n++) issue(OP_FAIL);
		run(OP_FAIL);
		slot_is(8'hFF);
	endtask

	task automatic t_group();
		apb(1'b1, OFF_CONFIG, 32'h5A);
		arg(8'h00, 8'h00, 8'h5A);
		run(OP_FLAG_MISMATCH_SELECT);
		state_is(TAG_READY);
		arg(8'h00, 8'h00, 8'h00);
		push_num();
		run(OP_FLAG_MISMATCH_SELECT);
		slot_is(8'h00);
		state_is(TAG_SELECTED);
		push_num();
		run(OP_FLAG_MISMATCH_SELECT);
		push_num();
		run(OP_FLAG_MATCH_DESELECT);
		state_is(TAG_SELECTED);
		arg(8'h00, 8'h00, 8'h5A);
		run(OP_FLAG_MATCH_DESELECT);
		state_is(TAG_READY);
		run(OP_FLAG_MATCH_DESELECT);
		arg(8'h00, 8'h00, 8'h00);
		push_num();
		run(OP_FLAG_MISMATCH_SELECT);
		arg(8'h00, 8'h00, 8'h5A);
		push_num();
		run(OP_FLAG_MISMATCH_DESELECT);
		arg(8'h00, 8'h00, 8'h00);
		run(OP_FLAG_MISMATCH_DESELECT);
		state_is(TAG_READY);
	endtask

	task automatic t_read();
		apb(1'b1, OFF_GIVEN_LO, TAG_NUM[31:0]);
		apb(1'b1, OFF_GIVEN_HI, TAG_NUM[63:32]);
		arg(8'h10, 8'h00, 8'h00);
		push_mem(8'h10, 8);
		run(OP_READ);
		lock_is(8'h10);
		state_is(TAG_TRANSFER);
		apb(1'b1, OFF_GIVEN_LO, TAG_NUM[31:0] ^ 32'h1);
		run(OP_READ);
		apb(1'b1, OFF_GIVEN_LO, TAG_NUM[31:0]);
		run(OP_INITIALIZE);
		state_is(TAG_READY);
		run(OP_SELECTED_FETCH);
		stall <= 1'b1;
		arg(8'hD8, 8'h01, 8'h00);
		push_mem(8'hD8, 16);
		run(OP_MULTI_BLOCK_FETCH);
		lock_is(8'h10);
		stall <= 1'b0;
		state_is(TAG_TRANSFER);
		arg(8'h30, 8'h00, 8'h00);
		push_mem(8'h30, 8);
		run(OP_SELECTED_FETCH);
		lock_is(8'h30);
		arg(8'h44, 8'h00, 8'h00);
		run(OP_VERIFY_BYTE);
		apb(1'b1, OFF_CONFIG, 32'h15A);
		push_mem(8'h44, 1);
		run(OP_VERIFY_BYTE);
		lock_is(8'h44);
		arg(8'h50, 8'hA0, 8'h00);
		push_mem(8'h50, 1);
		push_mem(8'h52, 1);
		run(OP_VERIFY_QUAD_FETCH);
		arg(8'h50, 8'h50, 8'h00);
		push_mem(8'h51, 1);
		push_mem(8'h53, 1);
		run(OP_VERIFY_QUAD_FETCH);
		lock_is(8'h44);
	endtask

	// command registers refuse writes while a reply is in flight
	task automatic t_locked();
		int b;
		stall <= 1'b1;
		arg(8'h60, 8'h00, 8'h00);
		push_mem(8'h60, 8);
		b = sink_u.cnt;
		apb(1'b1, OFF_CMD, {24'h0, OP_READ});
		apb(1'b1, OFF_ARG, 32'h00FF_FFFF);
		check("busy write err", 1, er);
		issue(OP_RESEND);
		stall <= 1'b0;
		check("reply count", 8, sink_u.cnt - b);
		foreach (ex[i]) check("reply byte", ex[i], sink_u.got[b + i]);
		ex.delete();
		lock_is(8'h60);
		apb(1'b0, OFF_ARG, 32'h0);
		check("arg kept", 32'h60, rd);
		apb(1'b0, OFF_CMD, 32'h0);
		check("last opcode", {24'h0, OP_READ}, rd);
		apb(1'b0, OFF_CONFIG, 32'h0);
		check("config", 32'h15A, rd);
	endtask

	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		stall   = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_arb();
		t_group();
		t_read();
		t_locked();
		summarize();
	end
endmodule
